/* File: common/cef_pkg.sv */
// constants and carrier types for the charger event flag register bank
package cef_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int unsigned REG_W        = 8;
  localparam logic [7:0]  CHG_OFS      = 8'h03;
  localparam logic [7:0]  FLT_OFS      = 8'h04;
  localparam logic [7:0]  ALM_OFS      = 8'h05;
  localparam logic [7:0]  MISC_OFS     = 8'h06;
  localparam logic [7:0]  FLAG_RST     = 8'h00;
  localparam logic [7:0]  UNMAPPED_VAL = 8'h00;

  // readable bits; reserved positions read as zero
  localparam logic [7:0]  CHG_MASK     = 8'h7F;
  localparam logic [7:0]  FLT_MASK     = 8'hBF;
  localparam logic [7:0]  ALM_MASK     = 8'hF1;
  localparam logic [7:0]  MISC_MASK    = 8'hFF;

  // ***************************************************************
  // serial register port
  // ***************************************************************
  localparam logic [6:0]  DEV_ADDR_DEF = 7'h6A;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam int unsigned ALARM_N      = 3;

  // ***************************************************************
  // carrier types
  // ***************************************************************
  typedef struct packed {
    logic taper;
    logic charge_done;
    logic input_current_limit;
    logic power_path_regulation;
    logic input_voltage_regulation;
    logic thermal_regulation;
    logic vin_above_uvlo;
    logic vin_above_bat_sleep;
    logic vin_below_ovp;
    logic input_overvoltage;
    logic battery_overcurrent;
    logic battery_undervoltage;
    logic thermistor_cold;
    logic thermistor_cool;
    logic thermistor_warm;
    logic thermistor_hot;
    logic thermistor_open;
  } cef_analog_s;

  typedef struct packed {
    logic [7:0] charger;
    logic [7:0] fault_thermal;
    logic [7:0] converter_alarm;
    logic [7:0] timer_misc;
  } cef_flags_s;

  typedef enum logic [2:0] {
    CEF_IDLE,
    CEF_ADDR,
    CEF_ACK_ADDR,
    CEF_PTR,
    CEF_ACK_WR,
    CEF_WR_DATA,
    CEF_RD_DATA,
    CEF_RD_ACK
  } cef_state_e;

endpackage

/* File: logic/cef_flag_bank.sv */
// charger event flag register bank with its two-wire register port
//
// Summary of operation
// [RQ1] charger flags at 0x3, reset zero, clear-on-read
// [RQ2] fault flags at 0x4, reset zero, clear-on-read
// [RQ3] alarm flags at 0x5, reset zero, clear-on-read
// [RQ4] misc flags at 0x6, reset zero, clear-on-read
// [RQ5] bit 6 set on taper phase entry
// [RQ6] bit 5 set on charge termination
// [RQ7] bit 4 set on input current limiting
// [RQ8] bit 3 set on power-path regulation
// [RQ9] bit 2 set on input-voltage regulation
// [RQ10] bit 1 set on thermal regulation
// [RQ11] bit 0 set on any power-good change
// [RQ12] fault bit 7 set on input overvoltage
// [RQ13] fault bit 5 set on battery overcurrent
// [RQ14] fault bit 4 reports battery undervoltage
// [RQ15] fault bits 3..0 cold/cool/warm/hot entry
// [RQ16] alarm bit 7 set on conversion done
// [RQ17] alarm bits 6..4 on comparator condition crossing
// [RQ18] alarm bit 0 set on open thermistor
// [RQ19] power good needs uvlo, sleep, ovp ok
// [RQ20] event during clearing read stays set
// [RQ21] reserved bits always read zero
`timescale 1ns/1ps

module cef_flag_bank #(
  parameter logic [6:0] DEV_ADDR      = cef_pkg::DEV_ADDR_DEF,
  parameter bit         BATUV_INVERT  = 1'b0
) (
  // clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                rst_n_in,
  // two-wire register port pins
  input  wire logic                                scl_in,
  input  wire logic                                sda_in,
  output logic                                     sda_out,
  output logic                                     sda_oe_out,
  // analog comparator status levels, asynchronous
  input  wire cef_pkg::cef_analog_s                analog_in,
  // converter and timer events, same clock
  input  wire logic                                adc_done_in,
  input  wire logic [cef_pkg::ALARM_N-1:0]         alarm_above_in,
  input  wire logic [cef_pkg::ALARM_N-1:0]         alarm_direction_in,
  input  wire logic [cef_pkg::REG_W-1:0]           misc_event_in,
  // flag contents for the interrupt logic
  output cef_pkg::cef_flags_s                      flags_out
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ***************************************************************
  // pin and status synchronisers
  // ***************************************************************
  cef_pkg::cef_analog_s an_meta_q;
  cef_pkg::cef_analog_s an_sync_q;
  cef_pkg::cef_analog_s an_prev_q;
  logic                 scl_meta_q;
  logic                 scl_sync_q;
  logic                 scl_prev_q;
  logic                 sda_meta_q;
  logic                 sda_sync_q;
  logic                 sda_prev_q;

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      an_meta_q  <= '0;
      an_sync_q  <= '0;
      an_prev_q  <= '0;
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      an_meta_q  <= analog_in;
      an_sync_q  <= an_meta_q;
      an_prev_q  <= an_sync_q;
      scl_meta_q <= scl_in;
      scl_sync_q <= scl_meta_q;
      scl_prev_q <= scl_sync_q;
      sda_meta_q <= sda_in;
      sda_sync_q <= sda_meta_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_sync_q & ~scl_prev_q;
  assign scl_fall  = ~scl_sync_q & scl_prev_q;
  assign bus_start = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
  assign bus_stop  = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;

  // ***************************************************************
  // event detection
  // ***************************************************************
  cef_pkg::cef_analog_s            an_rise;
  logic                            pgood_now;
  logic                            pgood_was;
  logic [cef_pkg::ALARM_N-1:0]     alarm_met;
  logic [cef_pkg::ALARM_N-1:0]     alarm_met_q;
  logic [cef_pkg::ALARM_N-1:0]     alarm_cross;
  logic                            batuv_event;

  assign an_rise   = an_sync_q & ~an_prev_q;
  // power good needs all three input comparators satisfied
  assign pgood_now = an_sync_q.vin_above_uvlo & an_sync_q.vin_above_bat_sleep & an_sync_q.vin_below_ovp; // RQ19
  assign pgood_was = an_prev_q.vin_above_uvlo & an_prev_q.vin_above_bat_sleep & an_prev_q.vin_below_ovp; // RQ19

  // comparator condition follows each direction bit
  assign alarm_met   = ~(alarm_above_in ^ alarm_direction_in);
  assign alarm_cross = alarm_met & ~alarm_met_q; // RQ17

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      alarm_met_q <= '0;
    else
      alarm_met_q <= alarm_met;
  end

  // undervoltage detection edge, or its release when inverted
  assign batuv_event = BATUV_INVERT ? (~an_sync_q.battery_undervoltage & an_prev_q.battery_undervoltage)
                                    : an_rise.battery_undervoltage; // RQ14

  logic [7:0] set_chg;
  logic [7:0] set_flt;
  logic [7:0] set_alm;
  logic [7:0] set_misc;

  assign set_chg = {1'b0,
                    an_rise.taper,                    // RQ5
                    an_rise.charge_done,              // RQ6
                    an_rise.input_current_limit,      // RQ7
                    an_rise.power_path_regulation,    // RQ8
                    an_rise.input_voltage_regulation, // RQ9
                    an_rise.thermal_regulation,       // RQ10
                    pgood_now ^ pgood_was};           // RQ11

  assign set_flt = {an_rise.input_overvoltage,        // RQ12
                    1'b0,
                    an_rise.battery_overcurrent,      // RQ13
                    batuv_event,                      // RQ14
                    an_rise.thermistor_cold,          // RQ15
                    an_rise.thermistor_cool,
                    an_rise.thermistor_warm,
                    an_rise.thermistor_hot};

  assign set_alm = {adc_done_in,                      // RQ16
                    alarm_cross,                      // RQ17
                    3'h0,
                    an_rise.thermistor_open};         // RQ18

  assign set_misc = misc_event_in;

  // ***************************************************************
  // register port state machine
  // ***************************************************************
  cef_pkg::cef_state_e state_q;
  logic [3:0]          bit_cnt_q;
  logic [7:0]          rx_q;
  logic [7:0]          tx_q;
  logic [7:0]          ptr_q;
  logic                rd_mode_q;
  logic                master_nack_q;
  logic                sda_oe_q;
  logic                load_rd;
  logic [7:0]          rd_byte;
  logic                byte_done;

  assign byte_done = scl_fall & (bit_cnt_q == cef_pkg::BYTE_BITS);

  // a byte leaves the bank only when the host clocks it out
  assign load_rd = scl_fall & ((state_q == cef_pkg::CEF_ACK_ADDR & rd_mode_q)
                             | (state_q == cef_pkg::CEF_RD_ACK & ~master_nack_q));

  always_comb
  begin
    unique case (ptr_q)
      cef_pkg::CHG_OFS:  rd_byte = flags_out.charger & cef_pkg::CHG_MASK;          // RQ21
      cef_pkg::FLT_OFS:  rd_byte = flags_out.fault_thermal & cef_pkg::FLT_MASK;    // RQ21
      cef_pkg::ALM_OFS:  rd_byte = flags_out.converter_alarm & cef_pkg::ALM_MASK;  // RQ21
      cef_pkg::MISC_OFS: rd_byte = flags_out.timer_misc & cef_pkg::MISC_MASK;
      default:           rd_byte = cef_pkg::UNMAPPED_VAL;
    endcase
  end

  // bit counter and receive shift register sample on rising clock
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bit_cnt_q     <= '0;
      rx_q          <= '0;
      master_nack_q <= 1'b1;
    end
    else if (bus_start || (scl_fall && (state_q == cef_pkg::CEF_ACK_ADDR || state_q == cef_pkg::CEF_ACK_WR
                                     || state_q == cef_pkg::CEF_RD_ACK)))
      bit_cnt_q <= '0;
    else if (scl_rise)
    begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      rx_q      <= {rx_q[6:0], sda_sync_q};
      if (state_q == cef_pkg::CEF_RD_ACK)
        master_nack_q <= sda_sync_q;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q   <= cef_pkg::CEF_IDLE;
      rd_mode_q <= 1'b0;
      ptr_q     <= '0;
      tx_q      <= '0;
      sda_oe_q  <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_q  <= cef_pkg::CEF_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (bus_start)
    begin
      state_q  <= cef_pkg::CEF_ADDR;
      sda_oe_q <= 1'b0;
    end
    else if (scl_fall)
    begin
      unique case (state_q)
        cef_pkg::CEF_IDLE:
          sda_oe_q <= 1'b0;
        cef_pkg::CEF_ADDR:
          if (byte_done)
          begin
            if (rx_q[7:1] == DEV_ADDR)
            begin
              rd_mode_q <= rx_q[0];
              sda_oe_q  <= 1'b1;
              state_q   <= cef_pkg::CEF_ACK_ADDR;
            end
            else
              state_q <= cef_pkg::CEF_IDLE;
          end
        cef_pkg::CEF_ACK_ADDR:
          if (rd_mode_q)
          begin
            tx_q     <= rd_byte;
            ptr_q    <= ptr_q + 8'h01;
            sda_oe_q <= ~rd_byte[7];
            state_q  <= cef_pkg::CEF_RD_DATA;
          end
          else
          begin
            sda_oe_q <= 1'b0;
            state_q  <= cef_pkg::CEF_PTR;
          end
        cef_pkg::CEF_PTR:
          if (byte_done)
          begin
            ptr_q    <= rx_q;
            sda_oe_q <= 1'b1;
            state_q  <= cef_pkg::CEF_ACK_WR;
          end
        cef_pkg::CEF_ACK_WR:
        begin
          sda_oe_q <= 1'b0;
          state_q  <= cef_pkg::CEF_WR_DATA;
        end
        cef_pkg::CEF_WR_DATA:
          // flag registers ignore written data, the pointer still advances
          if (byte_done)
          begin
            ptr_q    <= ptr_q + 8'h01;
            sda_oe_q <= 1'b1;
            state_q  <= cef_pkg::CEF_ACK_WR;
          end
        cef_pkg::CEF_RD_DATA:
          if (byte_done)
          begin
            sda_oe_q <= 1'b0;
            state_q  <= cef_pkg::CEF_RD_ACK;
          end
          else
          begin
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= ~tx_q[6];
          end
        cef_pkg::CEF_RD_ACK:
          if (master_nack_q)
          begin
            sda_oe_q <= 1'b0;
            state_q  <= cef_pkg::CEF_IDLE;
          end
          else
          begin
            tx_q     <= rd_byte;
            ptr_q    <= ptr_q + 8'h01;
            sda_oe_q <= ~rd_byte[7];
            state_q  <= cef_pkg::CEF_RD_DATA;
          end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  assign sda_oe_out = sda_oe_q;

  // ***************************************************************
  // flag registers
  // ***************************************************************
  logic [7:0] clr_chg;
  logic [7:0] clr_flt;
  logic [7:0] clr_alm;
  logic [7:0] clr_misc;

  assign clr_chg  = {8{load_rd & (ptr_q == cef_pkg::CHG_OFS)}};   // RQ1
  assign clr_flt  = {8{load_rd & (ptr_q == cef_pkg::FLT_OFS)}};   // RQ2
  assign clr_alm  = {8{load_rd & (ptr_q == cef_pkg::ALM_OFS)}};   // RQ3
  assign clr_misc = {8{load_rd & (ptr_q == cef_pkg::MISC_OFS)}};  // RQ4

  // set wins over the clearing read in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      flags_out.charger         <= cef_pkg::FLAG_RST; // RQ1
      flags_out.fault_thermal   <= cef_pkg::FLAG_RST; // RQ2
      flags_out.converter_alarm <= cef_pkg::FLAG_RST; // RQ3
      flags_out.timer_misc      <= cef_pkg::FLAG_RST; // RQ4
    end
    else
    begin
      flags_out.charger         <= (flags_out.charger & ~clr_chg) | (set_chg & cef_pkg::CHG_MASK);           // RQ20
      flags_out.fault_thermal   <= (flags_out.fault_thermal & ~clr_flt) | (set_flt & cef_pkg::FLT_MASK);     // RQ20
      flags_out.converter_alarm <= (flags_out.converter_alarm & ~clr_alm) | (set_alm & cef_pkg::ALM_MASK);   // RQ20
      flags_out.timer_misc      <= (flags_out.timer_misc & ~clr_misc) | (set_misc & cef_pkg::MISC_MASK);     // RQ20
    end
  end

endmodule

/* File: verif/cef_flag_bank_props.sv */
// assertion checker for the charger event flag bank
`timescale 1ns/1ps

module cef_flag_bank_props (
  // clock and reset
  input wire logic                        clk_in,
  input wire logic                        rst_n_in,
  // register port pins
  input wire logic                        scl_in,
  input wire logic                        sda_in,
  input wire logic                        sda_out,
  input wire logic                        sda_oe_out,
  // event sources and flags
  input wire cef_pkg::cef_analog_s        analog_in,
  input wire logic                        adc_done_in,
  input wire logic [cef_pkg::ALARM_N-1:0] alarm_above_in,
  input wire logic [cef_pkg::ALARM_N-1:0] alarm_direction_in,
  input wire logic [cef_pkg::REG_W-1:0]   misc_event_in,
  input wire cef_pkg::cef_flags_s         flags_out
);
  logic [2:0]  cnt_q;
  logic [2:0]  cond_q;
  logic [2:0]  cond;
  logic [2:0]  rise;
  logic [31:0] fl;
  logic        live;
  logic        pg;
  assign cond = ~(alarm_above_in ^ alarm_direction_in);
  assign rise = cond & ~cond_q;
  assign fl   = flags_out;
  assign live = (cnt_q == 3'h4);
  assign pg   = analog_in.vin_above_uvlo & analog_in.vin_above_bat_sleep & analog_in.vin_below_ovp;
  // cycles since reset release, saturating
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_q <= 3'h0;
    else if (!live)
      cnt_q <= cnt_q + 3'h1;
  end
  // comparator condition one cycle back; reset high so no false rise
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cond_q <= 3'h7;
    else
      cond_q <= cond;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_sets(b);
    ##[1:4] b;
  endsequence
  property p_reset_zero;
    $rose(rst_n_in) |-> fl == 32'h0;
  endproperty
  property p_reserved;
    (fl & ~{cef_pkg::CHG_MASK, cef_pkg::FLT_MASK, cef_pkg::ALM_MASK, cef_pkg::MISC_MASK}) == 32'h0;
  endproperty
  property p_clear_on_read;
    (|($past(fl) & ~fl)) |-> !scl_in;
  endproperty
  property p_taper;
    live && $rose(analog_in.taper) |-> s_sets(flags_out.charger[6]);
  endproperty
  property p_open;
    live && $rose(analog_in.thermistor_open) |-> s_sets(flags_out.converter_alarm[0]);
  endproperty
  property p_pgood;
    live && $changed(pg) |-> s_sets(flags_out.charger[0]);
  endproperty
  property p_adc;
    live && adc_done_in |=> flags_out.converter_alarm[7];
  endproperty
  property p_alarm;
    live && (|rise) |=> (flags_out.converter_alarm[6:4] & $past(rise)) == $past(rise);
  endproperty
  property p_misc;
    live && (|misc_event_in) |=> (flags_out.timer_misc & $past(misc_event_in)) == $past(misc_event_in);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");
  a_reserved: assert property (p_reserved) else $error("reserved flag bit set");
  a_clear_on_read: assert property (p_clear_on_read) else $error("flag cleared outside a read");
  a_taper: assert property (p_taper) else $error("taper entry not flagged");
  a_open: assert property (p_open) else $error("open thermistor not flagged");
  a_pgood: assert property (p_pgood) else $error("power good change not flagged");
  a_adc: assert property (p_adc) else $error("conversion done not flagged");
  a_alarm: assert property (p_alarm) else $error("alarm crossing not flagged");
  a_misc: assert property (p_misc) else $error("misc event lost");
endmodule

bind cef_flag_bank cef_flag_bank_props i_props (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .analog_in(analog_in), .adc_done_in(adc_done_in),
  .alarm_above_in(alarm_above_in), .alarm_direction_in(alarm_direction_in), .misc_event_in(misc_event_in),
  .flags_out(flags_out));

/* File: verif/cef_host_model.sv */
// two-wire host model that reads and writes the flag bank registers
`timescale 1ns/1ps

module cef_host_model (
  // clock
  input  wire logic clk_in,
  // device pin drive: value and enable
  input  wire logic sda_oe_in,
  input  wire logic sda_val_in,
  // bus lines as seen on the wire
  output logic      scl_out,
  output logic      sda_out
);
  logic       drv;
  logic       nack;
  logic [7:0] rd [4];
  // pull-up: line is high unless someone pulls low; an enabled device drives its pin value
  assign sda_out = drv & (sda_oe_in ? sda_val_in : 1'b1);
  initial
  begin
    scl_out = 1'b1;
    drv = 1'b1;
    nack = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  // data moves one cycle after the clock fell, sampled before it falls
  task automatic bit_io(input logic b, output logic s);
    @(negedge clk_in);
    drv = b;
    half();
    scl_out = 1'b1;
    half();
    s = sda_out;
    scl_out = 1'b0;
  endtask
  task automatic start();
    @(negedge clk_in);
    drv = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    drv = 1'b0;
    half();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    @(negedge clk_in);
    drv = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    drv = 1'b1;
    half();
  endtask
  task automatic wr_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    nack = nack | s;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    nack = 1'b0;
    start();
    wr_byte({dev, 1'b0});
    wr_byte(ptr);
    wr_byte(d);
    stop();
  endtask
  task automatic read_regs(input logic [7:0] ptr, input int n);
    nack = 1'b0;
    start();
    wr_byte({cef_pkg::DEV_ADDR_DEF, 1'b0});
    wr_byte(ptr);
    start();
    wr_byte({cef_pkg::DEV_ADDR_DEF, 1'b1});
    for (int k = 0; k < n; k++)
      rd_byte(k == n - 1, rd[k]);
    stop();
  endtask
endmodule

/* File: verif/cef_flag_bank_tb.sv */
// self-checking testbench for the charger event flag bank
`timescale 1ns/1ps

module cef_flag_bank_tb;
  logic                 clk;
  logic                 rst_n;
  logic                 scl;
  logic                 sda;
  logic                 sda_val;
  logic                 sda_oe;
  cef_pkg::cef_analog_s ana;
  logic                 adc_done;
  logic [2:0]           above;
  logic [2:0]           dirn;
  logic [7:0]           misc;
  cef_pkg::cef_flags_s  flags;
  cef_pkg::cef_flags_s  flags_inv;
  int                   n_mismatch;
  int                   compares;
  // status level steps and the flag byte each one leaves
  localparam logic [16:0] AV [17] = '{17'h00600, 17'h00700, 17'h00500, 17'h10000, 17'h08000, 17'h04000,
    17'h02000, 17'h01000, 17'h00800, 17'h00080, 17'h00040, 17'h00020, 17'h00010, 17'h00008, 17'h00004,
    17'h00002, 17'h00001};
  localparam logic [7:0] AE [17] = '{8'h00, 8'h01, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h80,
    8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h01};

  cef_flag_bank i_dut (.clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_val),
    .sda_oe_out(sda_oe), .analog_in(ana), .adc_done_in(adc_done), .alarm_above_in(above),
    .alarm_direction_in(dirn), .misc_event_in(misc), .flags_out(flags));
  // second bank flags undervoltage on leaving the region; it follows the same bus without driving it
  cef_flag_bank #(.BATUV_INVERT(1'b1)) i_dut_inv (.clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(), .analog_in(ana), .adc_done_in(adc_done), .alarm_above_in(above),
    .alarm_direction_in(dirn), .misc_event_in(misc), .flags_out(flags_inv));
  cef_host_model i_host (.clk_in(clk), .sda_oe_in(sda_oe), .sda_val_in(sda_val), .scl_out(scl), .sda_out(sda));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd1(input logic [7:0] ptr, input logic [7:0] exp);
    i_host.read_regs(ptr, 1);
    chk(i_host.rd[0], exp);
    chk({7'h00, i_host.nack}, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    ana = cef_pkg::cef_analog_s'(17'h00000);
    adc_done = 1'b0;
    above = 3'h0;
    dirn = 3'h7;
    misc = 8'h00;
    n_mismatch = 0;
    compares = 0;
    idle(5);
    rst_n = 1'b1;
    idle(8);
    i_host.read_regs(8'h03, 4);
    for (int k = 0; k < 4; k++)
      chk(i_host.rd[k], 8'h00);
    for (int i = 0; i < 17; i++)
    begin
      ana = cef_pkg::cef_analog_s'(AV[i]);
      idle(10);
      if (i == 11 || i == 12)
        chk({7'h00, flags_inv.fault_thermal[4]}, (i == 12) ? 8'h01 : 8'h00);
      rd1((i < 9) ? 8'h03 : (i < 16) ? 8'h04 : 8'h05, AE[i]);
      rd1((i < 9) ? 8'h03 : (i < 16) ? 8'h04 : 8'h05, 8'h00);
    end
    adc_done = 1'b1;
    above = 3'h7;
    misc = 8'hA5;
    idle(1);
    adc_done = 1'b0;
    misc = 8'h00;
    dirn = 3'h0;
    idle(4);
    i_host.read_regs(8'h05, 2);
    chk(i_host.rd[0], 8'hF0);
    chk(i_host.rd[1], 8'hA5);
    above = 3'h0;
    idle(2);
    rd1(8'h05, 8'h70);
    // event held through the clearing read must survive it
    misc = 8'h3C;
    rd1(8'h06, 8'h3C);
    misc = 8'h00;
    rd1(8'h06, 8'h3C);
    rd1(8'h06, 8'h00);
    misc = 8'h01;
    idle(1);
    misc = 8'h00;
    i_host.write_reg(cef_pkg::DEV_ADDR_DEF, 8'h06, 8'hFF);
    chk({7'h00, i_host.nack}, 8'h00);
    rd1(8'h06, 8'h01);
    rd1(8'h07, 8'h00);
    i_host.write_reg(cef_pkg::DEV_ADDR_DEF ^ 7'h01, 8'h03, 8'h00);
    chk({7'h00, i_host.nack}, 8'h01);
    misc = 8'hFF;
    idle(1);
    misc = 8'h00;
    idle(1);
    rst_n = 1'b0;
    idle(2);
    chk(flags.timer_misc, 8'h00);
    rst_n = 1'b1;
    idle(8);
    rd1(8'h06, 8'h00);
    stop_test();
  end
endmodule
